/* pkg/pbe_consts.svh */
// constants of the pixel-bus endian correction front end
// Behaviour
// - Out of reset the bus is little-endian, endian select at zero.
// - Endian select at one reverses the bits inside each pixel field.
// - Fields leave each word in ascending order from the lowest inputs.
// - The in-field reversal is the same at 8, 4, 2 and 1 bit per pixel.
// - 12-, 16- and 24-bit color run in both endian modes on one wiring.
// - Big-endian 16-bit color: first word on inputs 0-15, bits put back.
`ifndef PBE_CONSTS_SVH
`define PBE_CONSTS_SVH

`define PBE_BUS_W 32
`define PBE_ENDIAN_BIT 3
`define PBE_ENDIAN_RST 1'b0
`define PBE_DEPTH_RST 3'h3
`define PBE_CNT_W 6

`endif

/* pkg/pbe_pkg.sv */
// types of the pixel-bus endian correction front end
package pbe_pkg;

  // field width is 2**code bits; 12-bit color rides in a 16-bit field,
  // 24-bit color in the full word
  typedef enum logic [2:0] {
    PBE_D1 = 3'h0,
    PBE_D2 = 3'h1,
    PBE_D4 = 3'h2,
    PBE_D8 = 3'h3,
    PBE_D16 = 3'h4,
    PBE_D32 = 3'h5
  } pbe_depth_e;

  typedef struct packed {
    logic big_endian;
    pbe_depth_e depth;
  } pbe_cfg_s;

  typedef enum logic {
    PBE_IDLE = 1'b0,
    PBE_SHIFT = 1'b1
  } pbe_state_e;

endpackage

/* verilog/pbe_field_reverse.sv */
// in-field bit reversal of a bus word for every pixel depth
`timescale 1ns/100ps
module pbe_field_reverse
  import pbe_pkg::*;
#(
  parameter int BUS_W = 32
) (
  input wire logic [BUS_W-1:0] din,
  input wire pbe_depth_e depth,
  output logic [BUS_W-1:0] dout
);

  localparam int NW = 6;

  if (BUS_W != 32) begin : g_bus_w_bad
    $error("pbe_field_reverse: BUS_W must be 32");
  end

  logic [BUS_W-1:0] rv [NW];

  // **********************************************
  // reversal inside fields of 2**k bits
  // **********************************************
  // bit i of a field of width w maps to bit i xor (w-1)
  for (genvar k = 0; k < NW; k++) begin : g_w
    for (genvar i = 0; i < BUS_W; i++) begin : g_b
      assign rv[k][i] = din[i ^ ((1 << k) - 1)];
    end
  end

  wire [2:0] sel = (depth > PBE_D32) ? 3'h5 : depth;

  assign dout = rv[sel];

endmodule

/* verilog/pbe_top.sv */
// pixel-bus front end: endian correction and field serialiser
`timescale 1ns/100ps
`include "pbe_consts.svh"
module pbe_top
  import pbe_pkg::*;
#(
  parameter int BUS_W = `PBE_BUS_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pbe_cfg_s cfg_in,
  input wire logic cfg_load,
  input wire logic [BUS_W-1:0] word_in,
  input wire logic word_valid,
  output logic word_ready,
  output logic [BUS_W-1:0] pix_data,
  output logic [5:0] pix_width,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic big_endian
);

  // refuse widths the fixed field geometry cannot serve
  if (BUS_W != `PBE_BUS_W) begin : g_bus_w_bad
    $error("pbe_top: BUS_W must be 32");
  end

  // **********************************************
  // configuration
  // **********************************************
  pbe_cfg_s cfg_reg;
  pbe_cfg_s cfg_next;
  pbe_cfg_s cfg_sel;

  // a setting written in the load cycle already steers that word
  assign cfg_sel = cfg_load ? cfg_in : cfg_reg;
  assign cfg_next = cfg_sel;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_reg.big_endian <= `PBE_ENDIAN_RST;
      cfg_reg.depth <= pbe_depth_e'(`PBE_DEPTH_RST);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign big_endian = cfg_reg.big_endian;

  // **********************************************
  // field geometry
  // **********************************************
  wire pbe_depth_e dsel = (cfg_sel.depth > PBE_D32) ? PBE_D32 : cfg_sel.depth;
  wire [5:0] fw_sel = 6'(32'd1 << dsel);
  wire [`PBE_CNT_W-1:0] nf_sel = `PBE_CNT_W'(32'd32 >> dsel);
  wire [BUS_W-1:0] mask_sel = ~({BUS_W{1'b1}} << fw_sel);

  // **********************************************
  // endian correction
  // **********************************************
  logic [BUS_W-1:0] rev_word;

  pbe_field_reverse #(
    .BUS_W(BUS_W)
  ) u_rev (
    .din(word_in),
    .depth(dsel),
    .dout(rev_word)
  );

  // the board already swapped the bus, so field order is right and only
  // the bits inside each field need turning back
  wire [BUS_W-1:0] corr_word =
    cfg_sel.big_endian ? rev_word : word_in;

  // **********************************************
  // serialiser
  // **********************************************
  pbe_state_e state_reg;
  pbe_state_e state_next;
  logic [BUS_W-1:0] shift_reg;
  logic [BUS_W-1:0] shift_next;
  logic [BUS_W-1:0] pix_reg;
  logic [BUS_W-1:0] pix_next;
  logic [5:0] fw_reg;
  logic [5:0] fw_next;
  logic [BUS_W-1:0] mask_reg;
  logic [BUS_W-1:0] mask_next;
  logic [`PBE_CNT_W-1:0] cnt_reg;
  logic [`PBE_CNT_W-1:0] cnt_next;

  wire busy = (state_reg == PBE_SHIFT);
  wire last = (cnt_reg == '0);
  wire take = busy && pix_ready;
  wire load = word_valid && word_ready;
  wire adv = take && !last;

  assign word_ready = !busy || (pix_ready && last);

  // lowest field first, the rest moves down one field per pixel
  assign shift_next = load ? (corr_word >> fw_sel)
                    : adv ? (shift_reg >> fw_reg)
                    : shift_reg;
  assign pix_next = load ? (corr_word & mask_sel)
                  : adv ? (shift_reg & mask_reg)
                  : pix_reg;
  assign fw_next = load ? fw_sel : fw_reg;
  assign mask_next = load ? mask_sel : mask_reg;
  assign cnt_next = load ? `PBE_CNT_W'(nf_sel - 1'b1)
                  : adv ? `PBE_CNT_W'(cnt_reg - 1'b1)
                  : cnt_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PBE_IDLE: begin
        if (load) begin
          state_next = PBE_SHIFT;
        end
      end
      PBE_SHIFT: begin
        if (take && last && !load) begin
          state_next = PBE_IDLE;
        end
      end
      default: begin
        state_next = PBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= PBE_IDLE;
      shift_reg <= '0;
      pix_reg <= '0;
      fw_reg <= 6'h08;
      mask_reg <= 32'h000000FF;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      pix_reg <= pix_next;
      fw_reg <= fw_next;
      mask_reg <= mask_next;
      cnt_reg <= cnt_next;
    end
  end

  assign pix_data = pix_reg;
  assign pix_width = fw_reg;
  assign pix_valid = busy;

  // **********************************************
  // checks
  // **********************************************
  logic [BUS_W-1:0] word_q;
  logic load_q;
  pbe_cfg_s cfg_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_q <= '0;
      load_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      word_q <= word_in;
      load_q <= load;
      cfg_q <= cfg_sel;
    end
  end

  function automatic logic [31:0] rev_low(input logic [31:0] v,
                                          input int w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < w; i++) begin
      r[i] = v[w - 1 - i];
    end
    return r;
  endfunction

  wire [31:0] chk4 = rev_low(word_q, 4);
  wire [31:0] chk8 = rev_low(word_q, 8);
  wire [31:0] chk16 = rev_low(word_q, 16);
  wire [31:0] chk32 = rev_low(word_q, 32);

  AST_RESET_LITTLE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> !big_endian && !pix_valid && word_ready)
    else $error("endian select not clear after reset");

  AST_BIG_D8: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_q && cfg_q.big_endian && cfg_q.depth == PBE_D8
    |-> pix_data == chk8 && pix_width == 6'h08)
    else $error("8-bit field not reversed in big-endian");

  AST_ORDER_D8: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_q && !cfg_q.big_endian && cfg_q.depth == PBE_D8
    |-> pix_data == {24'h0, word_q[7:0]} &&
        shift_reg[23:0] == word_q[31:8] && cnt_reg == 6'h03)
    else $error("fields not taken lowest first");

  AST_BIG_D4: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_q && cfg_q.big_endian && cfg_q.depth == PBE_D4
    |-> pix_data == chk4 && cnt_reg == 6'h07)
    else $error("4-bit field not reversed in big-endian");

  AST_BIG_D1: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_q && cfg_q.depth == PBE_D1
    |-> pix_data == {31'h0, word_q[0]} && cnt_reg == 6'h1F)
    else $error("1-bit field wrong");

  AST_BIG_D32: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_q && cfg_q.big_endian && cfg_q.depth == PBE_D32
    |-> pix_data == chk32 && cnt_reg == 6'h00)
    else $error("full-word color not restored");

  AST_BIG_D16: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_q && cfg_q.big_endian && cfg_q.depth == PBE_D16
    |-> pix_data == chk16 && shift_reg[15:0] == rev_low(word_q >> 16, 16))
    else $error("16-bit color word not restored");

  AST_LOAD_CFG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load && cfg_load && cfg_in.big_endian && cfg_in.depth == PBE_D8
    |=> pix_data == chk8 && big_endian)
    else $error("setting in load cycle not applied to that word");

endmodule

/* bench/pbe_vram_src.sv */
// video memory source model feeding the pixel bus
`timescale 1ns/100ps
module pbe_vram_src (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rev,
  input wire logic word_ready,
  output logic [31:0] word_in,
  output logic word_valid
);
  logic [31:0] q[$];
  logic acc;
  function automatic logic [31:0] swap(input logic [31:0] v);
    for (int i = 0; i < 32; i++) swap[i] = v[31 - i];
  endfunction
  initial begin
    word_in = '0;
    word_valid = 0;
    acc = 0;
  end
  always @(posedge clk_sys) acc <= rst_n && word_valid && word_ready;
  // lines keep changing while no word is offered
  always @(negedge clk_sys) begin
    #2;
    if (acc && q.size() > 0) void'(q.pop_front());
    word_valid = q.size() > 0;
    if (word_valid) word_in = rev ? swap(q[0]) : q[0];
    else word_in = ~word_in;
  end
endmodule

/* bench/pixel_bus_endian_correction_tb.sv */
// testbench of the pixel-bus endian correction front end
`timescale 1ns/100ps
module pixel_bus_endian_correction_tb;
  import pbe_pkg::*;
  logic clk_sys = 0;
  logic rst_n = 0;
  pbe_cfg_s cfg_in = '0;
  logic cfg_load = 0;
  logic rev = 0;
  logic pix_ready = 0;
  logic [31:0] word_in, pix_data;
  logic word_valid, word_ready, pix_valid, big_endian;
  logic [5:0] pix_width;
  logic [31:0] got[$];
  logic [5:0] gw[$];
  int miscompares = 0;
  int n_checks = 0;
  always #10 clk_sys = ~clk_sys;
  pbe_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_in(cfg_in),
    .cfg_load(cfg_load), .word_in(word_in), .word_valid(word_valid),
    .word_ready(word_ready), .pix_data(pix_data), .pix_width(pix_width),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .big_endian(big_endian));
  pbe_vram_src src_u (.clk_sys(clk_sys), .rst_n(rst_n), .rev(rev),
    .word_ready(word_ready), .word_in(word_in), .word_valid(word_valid));
  always @(posedge clk_sys) begin
    if (pix_valid && pix_ready) begin
      got.push_back(pix_data);
      gw.push_back(pix_width);
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic test_reset();
    chk("big_endian", 0, big_endian);
    chk("pix_valid", 0, pix_valid);
    chk("pix_width", 8, pix_width);
    chk("word_ready", 1, word_ready);
    $display("test_reset done");
  endtask
  // reset in mid-word after big-endian and an out-of-range depth code
  task automatic test_midreset();
    @(negedge clk_sys);
    cfg_in = '{big_endian: 1'b1, depth: pbe_depth_e'(3'h7)};
    cfg_load = 1;
    rev = 1;
    pix_ready = 0;
    src_u.q.push_back(32'h12345678);
    @(negedge clk_sys);
    cfg_load = 0;
    chk("big_endian", 1, big_endian);
    chk("pix_valid", 1, pix_valid);
    chk("pix_width", 32, pix_width);
    chk("pix_data", 32'h12345678, pix_data);
    rst_n = 0;
    @(negedge clk_sys);
    rst_n = 1;
    @(negedge clk_sys);
    chk("big_endian", 0, big_endian);
    chk("pix_valid", 0, pix_valid);
    chk("word_ready", 1, word_ready);
    $display("test_midreset done");
  endtask
  // two words back to back, config given with the first word
  task automatic run(input logic be, input pbe_depth_e d,
      input logic [31:0] m, input logic stall);
    int w, n, t;
    logic [31:0] mk, e;
    w = 1 << d;
    n = 32 / w;
    mk = (w == 32) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
    got.delete();
    gw.delete();
    @(negedge clk_sys);
    cfg_in = '{big_endian: be, depth: d};
    cfg_load = 1;
    rev = be;
    src_u.q.push_back(m);
    src_u.q.push_back(~m);
    @(negedge clk_sys);
    cfg_load = 0;
    pix_ready = 1;
    for (t = 0; t < 300 && got.size() < 2 * n; t++) begin
      @(negedge clk_sys);
      pix_ready = stall ? ~pix_ready : 1'b1;
    end
    chk("field count", 2 * n, got.size());
    chk("pix_valid", 0, pix_valid);
    chk("word_ready", 1, word_ready);
    chk("big_endian", be, big_endian);
    for (t = 0; t < 2 * n && t < got.size(); t++) begin
      e = (t < n) ? m : ~m;
      e = (e >> ((be ? n - 1 - t % n : t % n) * w)) & mk;
      chk("pix_data", e, got[t]);
      chk("pix_width", w, gw[t]);
    end
    $display("run done be %0d depth %0d", be, d);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1;
    @(negedge clk_sys);
    test_reset();
    run(0, PBE_D8, 32'h44332211, 0);
    for (int d = 0; d < 6; d++) begin
      run(1, pbe_depth_e'(d), 32'hC0FFEE81, d[0]);
      run(0, pbe_depth_e'(d), 32'h5A3C9617, 1);
    end
    test_midreset();
    complete_run();
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
